// file: des_error_status.sv
// Drive error status: latched fault categories, error entry time and extra info
module des_error_status
  import des_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SECOND_CYCLES
) (
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        safe_torque_off_input_a_i,
  input  wire logic        safe_torque_off_input_b_i,
  input  wire logic        positive_limit_switch_i,
  input  wire logic        negative_limit_switch_i,
  input  wire logic        reference_switch_i,
  input  wire logic        general_error_i,
  input  wire logic        travel_range_error_i,
  input  wire logic        quick_stop_cmd_i,
  input  wire logic        serial_comm_lost_i,
  input  wire logic        eth_comm_lost_i,
  input  wire logic        mode_proc_error_i,
  input  wire logic [15:0] mode_proc_detail_i,
  input  wire logic        dc_below_qstop_i,
  input  wire logic        dc_below_off_i,
  input  wire logic        dc_over_i,
  input  wire logic        phase_overcurrent_i,
  input  wire logic        ctrl_supply_low_i,
  input  wire logic        power_stage_hot_i,
  input  wire logic        stall_detect_i,
  input  wire logic [2:0]  stall_class_i,
  input  wire logic        nv_checksum_bad_i,
  input  wire logic        nv_class_locked_i,
  input  wire logic        startup_fail_i,
  input  wire logic        startup_class_locked_i,
  input  wire logic [15:0] startup_cause_i,
  input  wire logic        internal_error_i,
  input  wire logic        error_reset_i,
  input  wire logic        rd_en_i,
  input  wire logic [15:0] rd_addr_i,
  output logic [31:0]      rd_data_o,
  output logic             rd_valid_o,
  output logic             rd_unmapped_o,
  output logic [31:0]      latched_fault_categories_o,
  output logic [2:0]       error_class_o,
  output logic             warning_o,
  output logic             quick_stop_o,
  output logic             power_stage_off_o,
  output logic             fatal_o,
  output logic             power_cycle_needed_o
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (SEC_CYCLES < 1) begin : g_bad_sec
    $error("SEC_CYCLES must be at least one");
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Pins are asynchronous; only the second stage feeds any logic
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic [4:0] pin_raw;

  assign pin_raw = {reference_switch_i, negative_limit_switch_i, positive_limit_switch_i,
                    safe_torque_off_input_b_i, safe_torque_off_input_a_i};

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_meta <= 5'h1f;
      pin_sync <= 5'h1f;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  wire safe_a    = pin_sync[0];
  wire safe_b    = pin_sync[1];
  // Switch inputs are low while active, so a broken line looks active too
  wire limit_hit = ~pin_sync[2] | ~pin_sync[3] | ~pin_sync[4];

  // ****************************************
  // Event to category mapping
  // ****************************************
  logic [31:0] evt;

  assign evt[BIT_GENERAL]     = general_error_i;
  assign evt[BIT_LIMIT]       = limit_hit;
  assign evt[BIT_RANGE]       = travel_range_error_i;
  assign evt[BIT_QSTOP]       = quick_stop_cmd_i;
  assign evt[BIT_STO_OFF]     = ~safe_a & ~safe_b;
  assign evt[5]               = 1'b0;
  assign evt[BIT_RS485]       = serial_comm_lost_i;
  assign evt[7]               = 1'b0;
  assign evt[BIT_ETH]         = eth_comm_lost_i;
  assign evt[9]               = 1'b0;
  assign evt[BIT_MODE_PROC]   = mode_proc_error_i;
  assign evt[13:11]           = 3'h0;
  assign evt[BIT_DC_UNDER]    = dc_below_qstop_i | dc_below_off_i;
  assign evt[BIT_DC_OVER]     = dc_over_i;
  assign evt[17:16]           = 2'h0;
  assign evt[BIT_OVERCURRENT] = phase_overcurrent_i;
  assign evt[19]              = 1'b0;
  assign evt[BIT_SUPPLY_LOW]  = ctrl_supply_low_i;
  assign evt[BIT_HOT]         = power_stage_hot_i;
  assign evt[BIT_STALL]       = stall_detect_i;
  assign evt[23]              = 1'b0;
  assign evt[BIT_STO_DIFF]    = safe_a ^ safe_b;
  assign evt[28:25]           = 4'h0;
  assign evt[BIT_NV_SUM]      = nv_checksum_bad_i;
  assign evt[BIT_STARTUP]     = startup_fail_i;
  assign evt[BIT_INTERNAL]    = internal_error_i;

  // ****************************************
  // Class of each category
  // ****************************************
  wire [2:0] nv_class    = nv_class_locked_i ? CLASS_LOCKED : CLASS_FATAL;
  wire [2:0] start_class = startup_class_locked_i ? CLASS_LOCKED : CLASS_FATAL;
  wire [2:0] uv_class    = dc_below_off_i ? CLASS_FATAL : CLASS_QSTOP_OFF;

  logic [2:0] cls [32];

  always_comb begin
    for (int b = 0; b < 32; b++) begin
      cls[b] = CLASS_WARN;
    end
    cls[BIT_LIMIT]       = CLASS_QSTOP;
    cls[BIT_RANGE]       = CLASS_QSTOP;
    cls[BIT_QSTOP]       = CLASS_QSTOP;
    cls[BIT_STO_OFF]     = CLASS_FATAL;
    cls[BIT_RS485]       = CLASS_COMM;
    cls[BIT_ETH]         = CLASS_COMM;
    cls[BIT_MODE_PROC]   = CLASS_QSTOP_OFF;
    cls[BIT_DC_UNDER]    = uv_class;
    cls[BIT_DC_OVER]     = CLASS_FATAL;
    cls[BIT_OVERCURRENT] = CLASS_FATAL;
    cls[BIT_SUPPLY_LOW]  = CLASS_SUPPLY;
    cls[BIT_HOT]         = CLASS_FATAL;
    cls[BIT_STALL]       = stall_class_i;
    cls[BIT_STO_DIFF]    = CLASS_LOCKED;
    cls[BIT_NV_SUM]      = nv_class;
    cls[BIT_STARTUP]     = start_class;
    cls[BIT_INTERNAL]    = CLASS_LOCKED;
  end

  // Highest class among events present this cycle
  logic [2:0] evt_class;

  always_comb begin
    evt_class = CLASS_WARN;
    for (int b = 0; b < 32; b++) begin
      if (evt[b] && cls[b] > evt_class) begin
        evt_class = cls[b];
      end
    end
  end

  // ****************************************
  // Latched categories
  // ****************************************
  logic [31:0] latched;
  logic [31:0] lock_bit;

  // Class-4 categories survive an error reset; only power-up clears them
  always_comb begin
    for (int b = 0; b < 32; b++) begin
      lock_bit[b] = (cls[b] == CLASS_LOCKED);
    end
  end

  for (genvar g = 0; g < 32; g++) begin : g_latch
    des_fault_latch #(
      .INIT (LATCHED_RESET[g])
    ) u_latch (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .set_i     (evt[g]),
      .clr_i     (error_reset_i & ~lock_bit[g]),
      .q_o       (latched[g])
    );
  end

  assign latched_fault_categories_o = latched;

  // ****************************************
  // Error class and reaction
  // ****************************************
  logic       locked;
  logic [2:0] base_class;
  logic [2:0] next_class;

  assign base_class = error_reset_i ? (locked ? CLASS_LOCKED : CLASS_WARN) : error_class_o;
  assign next_class = (evt_class > base_class) ? evt_class : base_class;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      error_class_o <= CLASS_WARN;
      locked        <= 1'b0;
    end else begin
      error_class_o <= next_class;
      locked        <= locked | (next_class == CLASS_LOCKED);
    end
  end

  assign warning_o            = (|latched) && (error_class_o == CLASS_WARN);
  assign quick_stop_o         = (error_class_o == CLASS_QSTOP) ||
                                (error_class_o == CLASS_QSTOP_OFF);
  assign power_stage_off_o    = (error_class_o >= CLASS_QSTOP_OFF);
  assign fatal_o              = (error_class_o >= CLASS_FATAL);
  assign power_cycle_needed_o = (error_class_o == CLASS_LOCKED);

  // ****************************************
  // Operating seconds counter
  // ****************************************
  logic [31:0] sec_div;
  logic [31:0] op_seconds;
  wire         sec_tick = (sec_div == 32'(SEC_CYCLES - 1));

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sec_div    <= 32'h0;
      op_seconds <= TIME_RESET;
    end else begin
      sec_div <= sec_tick ? 32'h0 : sec_div + 32'h1;
      // Saturates rather than wraps so old entries never look newer
      if (sec_tick && op_seconds < TIME_MAX_S) begin
        op_seconds <= op_seconds + 32'h1;
      end
    end
  end

  // ****************************************
  // Current error entry
  // ****************************************
  logic [31:0] error_entry_time;
  logic [15:0] error_entry_extra_info;
  wire  [31:0] new_bits = evt & ~latched;
  wire  [15:0] next_info = new_bits[BIT_MODE_PROC] ? mode_proc_detail_i :
                           new_bits[BIT_STARTUP]   ? startup_cause_i    : INFO_RESET;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      error_entry_time       <= TIME_RESET;
      error_entry_extra_info <= INFO_RESET;
    end else if (|new_bits) begin
      error_entry_time       <= op_seconds;
      error_entry_extra_info <= next_info;
    end
  end

  // ****************************************
  // Parameter read port
  // ****************************************
  wire hit_time = (rd_addr_i == ADDR_ENTRY_TIME);
  wire hit_info = (rd_addr_i == ADDR_ENTRY_INFO);
  wire hit_lat  = (rd_addr_i == ADDR_LATCHED);
  wire [31:0] rd_mux = hit_time ? error_entry_time :
                       hit_info ? {16'h0, error_entry_extra_info} :
                       hit_lat  ? latched : 32'h0;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_data_o     <= 32'h0;
      rd_valid_o    <= 1'b0;
      rd_unmapped_o <= 1'b0;
    end else begin
      rd_valid_o    <= rd_en_i;
      rd_unmapped_o <= rd_en_i & ~(hit_time | hit_info | hit_lat);
      if (rd_en_i) begin
        rd_data_o <= rd_mux;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  entry_time_cap_a: assert property (error_entry_time <= TIME_MAX_S)
    else $error("Entry time above its limit");

  time_capture_a: assert property ((|new_bits) |=> error_entry_time == $past(op_seconds))
    else $error("Entry time not captured");

  info_detail_a: assert property (new_bits[BIT_MODE_PROC] |=>
    error_entry_extra_info == $past(mode_proc_detail_i))
    else $error("Mode error detail not captured");

  event_latch_a: assert property ((|evt) |=> (latched & $past(evt)) == $past(evt))
    else $error("Signalled category not latched");

  limit_pin_a: assert property ((!positive_limit_switch_i)[*3] |-> ##[0:1] latched[BIT_LIMIT])
    else $error("Limit switch not latched");

  sto_both_a: assert property ((!safe_torque_off_input_a_i && !safe_torque_off_input_b_i)[*3]
    |-> ##[0:1] (latched[BIT_STO_OFF] && error_class_o >= CLASS_FATAL))
    else $error("Safe torque off not reported");

  sto_diff_a: assert property (evt[BIT_STO_DIFF] |=> power_cycle_needed_o)
    else $error("Differing inputs not class four");

  undervolt_class_a: assert property ((dc_below_off_i && !dc_over_i) ##0
    (error_class_o < CLASS_LOCKED) |=> error_class_o >= CLASS_FATAL)
    else $error("Deep undervoltage below class three");

  stall_class_a: assert property ((stall_detect_i && !error_reset_i)
    |=> error_class_o >= $past(stall_class_i))
    else $error("Stall class ignored");

  sticky_bit_a: assert property ((latched[BIT_QSTOP] && !error_reset_i)
    |=> latched[BIT_QSTOP])
    else $error("Latched bit dropped without reset");

  locked_hold_a: assert property (power_cycle_needed_o |=> power_cycle_needed_o)
    else $error("Class four cleared without power cycle");

  internal_lock_a: assert property (latched[BIT_INTERNAL] |=> latched[BIT_INTERNAL])
    else $error("Internal error bit cleared");

  read_time_a: assert property ((rd_en_i && hit_time) |=>
    (rd_valid_o && !rd_unmapped_o && rd_data_o == $past(error_entry_time)))
    else $error("Time read returned wrong data");

  reset_cover_c: cover property (latched[BIT_RANGE] ##1 error_reset_i ##1 !latched[BIT_RANGE]);
  locked_cover_c: cover property (power_cycle_needed_o ##1 error_reset_i);
  read_cover_c: cover property (rd_en_i && hit_info ##1 rd_valid_o);
  stall_cover_c: cover property (stall_detect_i && stall_class_i == CLASS_FATAL);

endmodule

// file: des_fault_latch.sv
// One sticky fault bit where a set beats a clear in the same cycle
module des_fault_latch
  import des_pkg::*;
#(
  parameter bit INIT = 1'b0
) (
  input  wire logic ref_clk_i,
  input  wire logic nrst_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      q_o
);

  // ****************************************
  // Latch
  // ****************************************
  logic next_q;

  assign next_q = set_i | (q_o & ~clr_i);

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q_o <= INIT;
    end else begin
      q_o <= next_q;
    end
  end

endmodule

// file: des_master_model.sv
// Fieldbus master model that issues parameter reads to the error status block
module des_master_model (
  input  wire logic        ref_clk_i,
  input  wire logic [31:0] rd_data_i,
  input  wire logic        rd_valid_i,
  input  wire logic        rd_unmapped_i,
  output logic             rd_en_o,
  output logic [15:0]      rd_addr_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Read access
  // ****************************************
  initial begin
    rd_en_o   = 1'b0;
    rd_addr_o = 16'h0000;
  end

  // Idle cycles first let the bench play a slow master
  task automatic rd(input int gap, input logic [15:0] addr, output logic [31:0] data,
                    output logic unm, output logic ok);
    int n;
    ok   = 1'b0;
    data = 32'h00000000;
    unm  = 1'b0;
    repeat (gap + 1) @(posedge ref_clk_i);
    rd_en_o   <= 1'b1;
    rd_addr_o <= addr;
    @(posedge ref_clk_i);
    rd_en_o   <= 1'b0;
    // Address is not held over idle time, so a stale value can not pass for a live one
    rd_addr_o <= ~addr;
    // Answer is taken at the edge that samples it; a later look misses the one-cycle pulse
    for (n = 0; n < 4 && ok == 1'b0; n++) begin
      @(posedge ref_clk_i);
      if (rd_valid_i === 1'b1) begin
        ok   = 1'b1;
        data = rd_data_i;
        unm  = rd_unmapped_i;
      end
    end
  endtask
endmodule

// file: des_pkg.sv
// Constants shared by the drive error status block
package des_pkg;

  // ****************************************
  // Parameter addresses
  // ****************************************
  localparam logic [15:0] ADDR_ENTRY_TIME  = 16'h3c06;
  localparam logic [15:0] ADDR_ENTRY_INFO  = 16'h3c08;
  localparam logic [15:0] ADDR_LATCHED     = 16'h3d00;

  // ****************************************
  // Field limits and reset values
  // ****************************************
  localparam logic [31:0] TIME_MAX_S       = 32'h1fffffff;
  localparam logic [31:0] TIME_RESET       = 32'h00000000;
  localparam logic [15:0] INFO_RESET       = 16'h0000;
  localparam logic [31:0] LATCHED_RESET    = 32'h00000000;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned SECOND_NS        = 1000000000;
  localparam int unsigned SECOND_CYCLES    = SECOND_NS / CLK_PERIOD_NS;

  // ****************************************
  // Error bit positions
  // ****************************************
  localparam int unsigned BIT_GENERAL      = 0;
  localparam int unsigned BIT_LIMIT        = 1;
  localparam int unsigned BIT_RANGE        = 2;
  localparam int unsigned BIT_QSTOP        = 3;
  localparam int unsigned BIT_STO_OFF      = 4;
  localparam int unsigned BIT_RS485        = 6;
  localparam int unsigned BIT_ETH          = 8;
  localparam int unsigned BIT_MODE_PROC    = 10;
  localparam int unsigned BIT_DC_UNDER     = 14;
  localparam int unsigned BIT_DC_OVER      = 15;
  localparam int unsigned BIT_OVERCURRENT  = 18;
  localparam int unsigned BIT_SUPPLY_LOW   = 20;
  localparam int unsigned BIT_HOT          = 21;
  localparam int unsigned BIT_STALL        = 22;
  localparam int unsigned BIT_STO_DIFF     = 24;
  localparam int unsigned BIT_NV_SUM       = 29;
  localparam int unsigned BIT_STARTUP      = 30;
  localparam int unsigned BIT_INTERNAL     = 31;

  // ****************************************
  // Error classes
  // ****************************************
  localparam logic [2:0] CLASS_WARN        = 3'h0;
  localparam logic [2:0] CLASS_QSTOP       = 3'h1;
  localparam logic [2:0] CLASS_QSTOP_OFF   = 3'h2;
  localparam logic [2:0] CLASS_FATAL       = 3'h3;
  localparam logic [2:0] CLASS_LOCKED      = 3'h4;
  localparam logic [2:0] CLASS_COMM        = 3'h0;
  localparam logic [2:0] CLASS_SUPPLY      = 3'h0;

endpackage

// file: testbench.sv
// Self-checking bench for the drive error status block
module testbench
  import des_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Signals and event table
  // ****************************************
  localparam int unsigned SEC = 10;
  // Events 0..15 drive the internal inputs, 16..20 the active-low pins
  localparam int BITS [21] = '{0, 2, 3, 6, 8, 10, 14, 14, 15, 18, 20, 21, 22, 29, 30, 31,
                               4, 24, 1, 1, 1};
  localparam int CLS  [21] = '{0, 1, 1, 0, 0, 2, 2, 3, 3, 3, 0, 3, 1, 3, 4, 4, 3, 4, 1, 1, 1};
  logic        ref_clk_i;
  logic        nrst_i;
  logic [15:0] ev;
  logic [4:0]  pin;
  logic        err_rst;
  logic        rd_en;
  logic [15:0] rd_addr;
  logic [31:0] rd_data;
  logic        rd_valid;
  logic        rd_unm;
  logic [31:0] latched;
  logic [2:0]  err_class;
  logic        qstop;
  logic        fatal;
  logic        pcycle;
  logic        warn;
  logic        pstage_off;
  logic [2:0]  stl_cls;
  int          err_count;
  int          cmp_count;

  des_error_status #(.SEC_CYCLES(SEC)) des_error_status_i (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .safe_torque_off_input_a_i(pin[0]), .safe_torque_off_input_b_i(pin[1]),
    .positive_limit_switch_i(pin[2]), .negative_limit_switch_i(pin[3]),
    .reference_switch_i(pin[4]), .general_error_i(ev[0]), .travel_range_error_i(ev[1]),
    .quick_stop_cmd_i(ev[2]), .serial_comm_lost_i(ev[3]), .eth_comm_lost_i(ev[4]),
    .mode_proc_error_i(ev[5]), .mode_proc_detail_i(16'h1234), .dc_below_qstop_i(ev[6]),
    .dc_below_off_i(ev[7]), .dc_over_i(ev[8]), .phase_overcurrent_i(ev[9]),
    .ctrl_supply_low_i(ev[10]), .power_stage_hot_i(ev[11]), .stall_detect_i(ev[12]),
    .stall_class_i(stl_cls), .nv_checksum_bad_i(ev[13]), .nv_class_locked_i(1'b0),
    .startup_fail_i(ev[14]), .startup_class_locked_i(1'b1), .startup_cause_i(16'h5a5a),
    .internal_error_i(ev[15]), .error_reset_i(err_rst), .rd_en_i(rd_en),
    .rd_addr_i(rd_addr), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .rd_unmapped_o(rd_unm),
    .latched_fault_categories_o(latched), .error_class_o(err_class), .warning_o(warn),
    .quick_stop_o(qstop), .power_stage_off_o(pstage_off), .fatal_o(fatal),
    .power_cycle_needed_o(pcycle));

  des_master_model des_master_model_i (
    .ref_clk_i(ref_clk_i), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
    .rd_unmapped_i(rd_unm), .rd_en_o(rd_en), .rd_addr_o(rd_addr));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [31:0] exp, input logic eu,
                       input string what);
    logic [31:0] d;
    logic        u;
    logic        ok;
    des_master_model_i.rd(a[0], a, d, u, ok);
    chk({31'h0, ok}, 32'h1, "read answer");
    chk(d, exp, what);
    chk({31'h0, u}, {31'h0, eu}, "unmapped flag");
  endtask

  task automatic do_reset();
    nrst_i  <= 1'b0;
    ev      <= 16'h0000;
    pin     <= 5'h1f;
    err_rst <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
  endtask

  // ****************************************
  // Clock, watchdog and tests
  // ****************************************
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // A full run needs about 620 cycles
  initial begin
    #200000;
    err_count++;
    $display("FAIL %0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    logic [31:0] d;
    logic        u;
    logic        ok;
    err_count = 0;
    cmp_count = 0;
    nrst_i    = 1'b0;
    ev        = 16'h0000;
    pin       = 5'h1f;
    err_rst   = 1'b0;
    stl_cls   = 3'h1;
    repeat (20) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rdchk(ADDR_ENTRY_TIME, TIME_RESET, 1'b0, "time after reset");
    rdchk(ADDR_ENTRY_INFO, 32'h0, 1'b0, "info after reset");
    rdchk(ADDR_LATCHED, LATCHED_RESET, 1'b0, "latched after reset");
    rdchk(16'h3c07, 32'h0, 1'b1, "unmapped read");
    // Each event alone: bit, class, extra info, then an error reset
    for (int k = 0; k < 21; k++) begin
      do_reset();
      if (k < 16) begin
        ev[k] <= 1'b1;
        @(posedge ref_clk_i);
        ev <= 16'h0000;
      end else begin
        pin <= (k == 16) ? 5'h1c : (k == 17) ? 5'h1d : (k == 18) ? 5'h1b :
               (k == 19) ? 5'h17 : 5'h0f;
        repeat (3) @(posedge ref_clk_i);
        pin <= 5'h1f;
      end
      repeat (5) @(posedge ref_clk_i);
      // Cause is gone by now, so the bit must be held by the latch
      rdchk(ADDR_LATCHED, 32'h1 << BITS[k], 1'b0, "latched bit");
      chk({29'h0, err_class}, CLS[k], "error class");
      chk({31'h0, qstop}, {31'h0, CLS[k] inside {1, 2}}, "quick stop");
      chk({31'h0, fatal}, {31'h0, CLS[k] >= 3}, "fatal");
      chk({31'h0, pcycle}, {31'h0, CLS[k] == 4}, "power cycle");
      chk({31'h0, warn}, {31'h0, CLS[k] == 0}, "warning");
      chk({31'h0, pstage_off}, {31'h0, CLS[k] >= 2}, "power stage off");
      rdchk(ADDR_ENTRY_INFO, (k == 5) ? 32'h1234 : (k == 14) ? 32'h5a5a : 32'h0, 1'b0,
            "extra info");
      err_rst <= 1'b1;
      @(posedge ref_clk_i);
      err_rst <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      rdchk(ADDR_LATCHED, (CLS[k] == 4) ? 32'h1 << BITS[k] : 32'h0, 1'b0,
            "after error reset");
    end
    // Stall class follows its configuration input
    do_reset();
    stl_cls <= CLASS_FATAL;
    ev[12]  <= 1'b1;
    @(posedge ref_clk_i);
    ev <= 16'h0000;
    repeat (2) @(posedge ref_clk_i);
    chk({29'h0, err_class}, {29'h0, CLASS_FATAL}, "stall class");
    chk({31'h0, fatal}, 32'h1, "stall fatal");
    // Set and error reset in one cycle: the set must win
    do_reset();
    ev[1]   <= 1'b1;
    err_rst <= 1'b1;
    @(posedge ref_clk_i);
    ev      <= 16'h0000;
    err_rst <= 1'b0;
    rdchk(ADDR_LATCHED, 32'h4, 1'b0, "set beats reset");
    // Seconds tick every SEC cycles counted from the first edge after release
    do_reset();
    repeat (95) @(posedge ref_clk_i);
    ev[0] <= 1'b1;
    @(posedge ref_clk_i);
    ev <= 16'h0000;
    des_master_model_i.rd(0, ADDR_ENTRY_TIME, d, u, ok);
    chk({31'h0, ok}, 32'h1, "time read answer");
    chk(d, 32'(97 / SEC), "entry time");
    end_sim();
  end
endmodule
